// *** common/pat_pkg.sv ***
package pat_pkg;
   // register indices on the management bus (5-bit register address)
   localparam logic [4:0] PAT_REG_ADDR_SPEED = 5'h19;
   localparam logic [4:0] PAT_REG_TEN_STATUS = 5'h1b;
   localparam logic [4:0] PAT_REG_TEN_CONFIG = 5'h1c;
   // station address and speed register fields
   localparam int PAT_SPEED_BIT = 6;
   localparam int PAT_CONN_BIT = 5;
   localparam int PAT_ADDR_MSB = 4;
   localparam int PAT_ADDR_W = 5;
   // ten base status field
   localparam int PAT_SER_BIT = 9;
   // ten base configuration fields
   localparam int PAT_LPE_BIT = 5;
   localparam int PAT_HBE_BIT = 4;
   localparam int PAT_MPS_BIT = 3;
   localparam int PAT_LSS_BIT = 2;
   localparam int PAT_JAB_BIT = 0;
   // reset values of the configuration bits
   localparam logic PAT_LPE_RST = 1'h1;
   localparam logic PAT_HBE_RST = 1'h1;
   localparam logic PAT_MPS_RST = 1'h1;
   localparam logic PAT_LSS_RST = 1'h0;
   localparam logic PAT_JAB_RST = 1'h1;
   localparam logic PAT_CONN_RST = 1'h0;
   localparam logic [4:0] PAT_ADDR_ZERO = 5'h00;
endpackage : pat_pkg

// *** hdl/pat_regs.sv ***
`timescale 1ns/1ps
module pat_regs
   import pat_pkg::*;
(
   input wire logic mclk_in, // 125 MHz system clock
   input wire logic rst_b_in, // sync reset, active low
   input wire logic [4:0] reg_addr_in, // management register address
   input wire logic reg_wr_in, // one-cycle write strobe
   input wire logic [15:0] reg_wdata_in, // write data
   output logic [15:0] reg_rdata_out, // read data for the addressed register
   input wire logic [pat_pkg::PAT_ADDR_W-1:0] station_address_straps_in, // address straps
   input wire logic serial_mode_strap_in, // serial mode strap pin
   input wire logic link_good_in, // basic status link bit from link logic
   input wire logic disconnect_ok_in, // disconnect function sees valid link
   input wire logic cfg_100_in, // configured for 100 Mb/s
   input wire logic autoneg_en_in, // autonegotiation enabled
   input wire logic full_duplex_in, // full duplex configured
   input wire logic transceiver_loopback_in, // loopback bit from loopback register
   input wire logic indicator_pin_mode_in, // indicator mode bit from coding register
   input wire logic indicator_normal_in, // normal function of first indicator
   output logic first_indicator_pin_out, // first indicator pin level
   output logic speed_10_out, // effective speed is 10 Mb/s
   output logic isolate_req_out, // request isolate in basic control register
   output logic serial_data_mode_out, // serial data mode active
   output logic link_pulse_tx_out, // transmit link pulses
   output logic force_link_good_out, // force good link condition
   output logic heartbeat_en_out, // heartbeat function active
   output logic unshielded_tx_pair_oe_out, // drive unshielded pair
   output logic shielded_tx_pair_oe_out, // drive shielded pair
   output logic reduced_squelch_select_out, // low squelch threshold
   output logic jabber_en_out // jabber function active
);
   import pat_pkg::*;

   typedef struct packed {
      logic [PAT_ADDR_W-1:0] addr;
      logic conn;
      logic ser;
      logic lpe;
      logic heartbeat_enable;
      logic mps;
      logic reduced_squelch_select;
      logic jab;
      logic [15:0] rdata;
   } pat_regs_t;
   pat_regs_t st_q, st_d;

   logic [PAT_ADDR_W-1:0] straps_s;
   logic ser_s;
   logic link_s;
   logic conn_s;
   logic strap_load;
   logic speed10;

   // every strap and status input crosses from outside through three stages
   pat_sync #(.W(PAT_ADDR_W + 3)) u_sync (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .d_in({station_address_straps_in, serial_mode_strap_in, link_good_in,
             disconnect_ok_in}),
      .q_out({straps_s, ser_s, link_s, conn_s})
   );

   pat_strap #(.W(PAT_ADDR_W + 1)) u_strap (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .pins_in({straps_s, ser_s}),
      .load_out(strap_load)
   );

   // speed: 10 when configured so, or forced by clearing link pulses under autoneg
   always_comb begin
      speed10 = !cfg_100_in;
      if (cfg_100_in && autoneg_en_in && !st_q.lpe) begin
         speed10 = 1'b1;
      end
   end

   // read mux; reserved bits read as zero, unmapped addresses read zero
   function automatic logic [15:0] rd_word(input logic [4:0] a, input pat_regs_t s,
                                           input logic sp);
      logic [15:0] w;
      w = 16'h0000;
      if (a == PAT_REG_ADDR_SPEED) begin
         w[PAT_SPEED_BIT] = sp;
         w[PAT_CONN_BIT] = s.conn;
         w[PAT_ADDR_MSB:0] = s.addr;
      end else if (a == PAT_REG_TEN_STATUS) begin
         w[PAT_SER_BIT] = s.ser;
      end else if (a == PAT_REG_TEN_CONFIG) begin
         w[PAT_LPE_BIT] = s.lpe;
         w[PAT_HBE_BIT] = s.heartbeat_enable;
         w[PAT_MPS_BIT] = s.mps;
         w[PAT_LSS_BIT] = s.reduced_squelch_select;
         w[PAT_JAB_BIT] = s.jab;
      end
      return w;
   endfunction : rd_word

   // register update: strap load, write decode, connect latch
   always_comb begin
      st_d = st_q;
      if (strap_load) begin
         st_d.addr = straps_s;
         st_d.ser = ser_s;
      end else if (reg_wr_in) begin
         if (reg_addr_in == PAT_REG_ADDR_SPEED) begin
            // speed and connect bits are read only, only the address field is taken
            st_d.addr = reg_wdata_in[PAT_ADDR_MSB:0];
         end else if (reg_addr_in == PAT_REG_TEN_STATUS) begin
            st_d.ser = reg_wdata_in[PAT_SER_BIT];
         end else if (reg_addr_in == PAT_REG_TEN_CONFIG) begin
            st_d.lpe = reg_wdata_in[PAT_LPE_BIT];
            st_d.heartbeat_enable = reg_wdata_in[PAT_HBE_BIT];
            st_d.mps = reg_wdata_in[PAT_MPS_BIT];
            st_d.reduced_squelch_select = reg_wdata_in[PAT_LSS_BIT];
            st_d.jab = reg_wdata_in[PAT_JAB_BIT];
         end
      end
      // latching low: a loss sticks until the register is read, then refreshes
      if (!conn_s) begin
         st_d.conn = 1'b0;
      end else if (reg_addr_in == PAT_REG_ADDR_SPEED && !reg_wr_in) begin
         st_d.conn = 1'b1;
      end else if (st_q.conn) begin
         st_d.conn = 1'b1;
      end
      st_d.rdata = rd_word(reg_addr_in, st_q, speed10);
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         st_q <= '0;
         st_q.conn <= PAT_CONN_RST;
         st_q.lpe <= PAT_LPE_RST;
         st_q.heartbeat_enable <= PAT_HBE_RST;
         st_q.mps <= PAT_MPS_RST;
         st_q.reduced_squelch_select <= PAT_LSS_RST;
         st_q.jab <= PAT_JAB_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // read data is registered: valid one cycle after the address is presented
   assign reg_rdata_out = st_q.rdata;

   // outputs to the datapath functions
   assign speed_10_out = speed10;
   assign isolate_req_out = (st_q.addr == PAT_ADDR_ZERO);
   assign serial_data_mode_out = st_q.ser && speed10;
   // at 100 Mb/s without autoneg the enable does not steer anything
   assign link_pulse_tx_out = speed10 && st_q.lpe;
   assign force_link_good_out = speed10 && !st_q.lpe;
   assign heartbeat_en_out = st_q.heartbeat_enable && !full_duplex_in;
   assign unshielded_tx_pair_oe_out = st_q.mps;
   assign shielded_tx_pair_oe_out = !st_q.mps;
   assign reduced_squelch_select_out = st_q.reduced_squelch_select;
   assign jabber_en_out = st_q.jab && (full_duplex_in || transceiver_loopback_in);
   assign first_indicator_pin_out = indicator_pin_mode_in ? st_q.conn
                                                          : indicator_normal_in;

   // exactly one transmit pair is ever driven
   AST_ONE_PAIR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      unshielded_tx_pair_oe_out != shielded_tx_pair_oe_out)
      else $error("both or neither transmit pair driven");
   AST_SPEED_RD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      reg_addr_in == PAT_REG_ADDR_SPEED ##1 1'b1 |->
      reg_rdata_out[PAT_SPEED_BIT] == $past(speed10))
      else $error("speed bit readback wrong");
   AST_ISOLATE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      strap_load && straps_s == PAT_ADDR_ZERO |=> isolate_req_out)
      else $error("zero address did not request isolate");
   AST_STRAP_ADDR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      strap_load |=> st_q.addr == $past(straps_s) && st_q.ser == $past(ser_s))
      else $error("straps not captured");
   AST_SER_SPEED: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !speed10 |-> !serial_data_mode_out)
      else $error("serial mode at 100 Mb/s");
   AST_CONN_LOW: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      !conn_s |=> !st_q.conn)
      else $error("connect status not latched low");
   AST_FORCE_10: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      cfg_100_in && autoneg_en_in && !st_q.lpe |-> speed_10_out && !link_pulse_tx_out)
      else $error("link pulse clear did not force 10 Mb/s");
   AST_HB_FDX: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      full_duplex_in |-> !heartbeat_en_out)
      else $error("heartbeat active in full duplex");
   AST_RO_WRITE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      reg_wr_in && reg_addr_in == PAT_REG_ADDR_SPEED && !strap_load |=>
      st_q.addr == $past(reg_wdata_in[PAT_ADDR_MSB:0]))
      else $error("address field write lost");
   AST_LED: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      indicator_pin_mode_in |-> first_indicator_pin_out == st_q.conn)
      else $error("indicator not showing connect status");
endmodule : pat_regs

// *** hdl/pat_strap.sv ***
`timescale 1ns/1ps
// captures the strap word a fixed number of cycles after reset release,
// long enough for the synchroniser to have settled on the pin levels
module pat_strap #(
   parameter int W = 6
) (
   input wire logic mclk_in, // system clock
   input wire logic rst_b_in, // sync reset, active low
   input wire logic [W-1:0] pins_in, // synchronised strap levels
   output logic load_out // one-cycle load pulse
);
   typedef struct packed {
      logic [2:0] cnt;
      logic done;
      logic load;
   } pat_strap_t;
   pat_strap_t st_q, st_d;

   // count out the synchroniser latency, then fire once
   always_comb begin
      st_d = st_q;
      st_d.load = 1'b0;
      if (!st_q.done) begin
         st_d.cnt = st_q.cnt + 3'h1;
         if (st_q.cnt == 3'h4) begin
            st_d.load = 1'b1;
            st_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign load_out = st_q.load;
endmodule : pat_strap

// *** hdl/pat_sync.sv ***
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once stages two and three agree
module pat_sync #(
   parameter int W = 1
) (
   input wire logic mclk_in, // system clock
   input wire logic rst_b_in, // sync reset, active low
   input wire logic [W-1:0] d_in, // asynchronous input
   output logic [W-1:0] q_out // filtered output
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } pat_sync_t;
   pat_sync_t st_q, st_d;

   // stage one feeds only stage two
   always_comb begin
      st_d = st_q;
      st_d.s1 = d_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < W; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.q[i] = st_q.s3[i];
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q_out = st_q.q;
endmodule : pat_sync

// *** test/pat_sme.sv ***
`timescale 1ns/1ps
// station management side: one register access at a time
module pat_sme
   import pat_pkg::*;
(
   input wire logic mclk_in, // system clock
   input wire logic [15:0] reg_rdata_in, // read data from the block
   output logic [4:0] reg_addr_out, // register address
   output logic reg_wr_out, // write strobe
   output logic [15:0] reg_wdata_out // write data
);
   initial begin
      reg_addr_out = 5'h05;
      reg_wr_out = 1'h0;
      reg_wdata_out = 16'h0000;
   end
   // reserved bits of mapped registers go out as zero with the strobe, read-only bits are left in
   function automatic logic [15:0] keep_mask(input logic [4:0] a);
      case (a)
         PAT_REG_ADDR_SPEED: return 16'h007f;
         PAT_REG_TEN_STATUS: return 16'h0200;
         PAT_REG_TEN_CONFIG: return 16'h003d;
         default: return 16'hffff;
      endcase
   endfunction : keep_mask
   // strobe stands one edge; read data is taken two edges after the address is driven
   task automatic access(input logic [4:0] a, input logic w, input logic [15:0] d,
                         output logic [15:0] q);
      @(posedge mclk_in);
      reg_addr_out <= a;
      reg_wr_out <= w;
      reg_wdata_out <= d & keep_mask(a);
      @(posedge mclk_in);
      reg_wr_out <= 1'h0;
      reg_wdata_out <= ~(d & keep_mask(a)); // stale data never lingers
      @(posedge mclk_in);
      q = reg_rdata_in;
   endtask : access
endmodule : pat_sme

// *** test/phy_addr_and_tenbase_cfg_regs_tb_top.sv ***
`timescale 1ns/1ps
module phy_addr_and_tenbase_cfg_regs_tb_top;
   import pat_pkg::*;
   logic mclk_in = 1'h0;
   logic rst_b_in = 1'h0;
   logic [4:0] reg_addr;
   logic reg_wr;
   logic [15:0] reg_wdata;
   logic [15:0] rdata;
   logic [4:0] straps = 5'h00;
   logic ser_strap = 1'h0;
   logic link_good = 1'h1;
   logic disc_ok = 1'h0;
   logic cfg_100 = 1'h0;
   logic an_en = 1'h0;
   logic fdx = 1'h0;
   logic lpbk = 1'h0;
   logic ind_mode = 1'h0;
   logic ind_norm = 1'h0;
   wire [10:0] pins; // one output port drives each bit
   logic [15:0] cfg_e;
   logic [4:0] addr_e;
   logic ser_e;
   logic conn_e;
   logic [15:0] q;
   logic [31:0] v;
   logic [4:0] a;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;

   always #4 mclk_in = ~mclk_in;

   pat_sme i_sme (.mclk_in(mclk_in), .reg_rdata_in(rdata), .reg_addr_out(reg_addr),
      .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata));

   pat_regs i_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr),
      .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata),
      .station_address_straps_in(straps), .serial_mode_strap_in(ser_strap),
      .link_good_in(link_good), .disconnect_ok_in(disc_ok), .cfg_100_in(cfg_100),
      .autoneg_en_in(an_en), .full_duplex_in(fdx), .transceiver_loopback_in(lpbk),
      .indicator_pin_mode_in(ind_mode), .indicator_normal_in(ind_norm),
      .first_indicator_pin_out(pins[0]), .speed_10_out(pins[10]),
      .isolate_req_out(pins[9]), .serial_data_mode_out(pins[8]),
      .link_pulse_tx_out(pins[7]), .force_link_good_out(pins[6]),
      .heartbeat_en_out(pins[5]), .unshielded_tx_pair_oe_out(pins[4]),
      .shielded_tx_pair_oe_out(pins[3]), .reduced_squelch_select_out(pins[2]),
      .jabber_en_out(pins[1]));

   // expected block outputs from the modelled register contents
   function automatic logic [10:0] exp_pins();
      logic s10;
      s10 = !cfg_100 | (an_en & !cfg_e[5]);
      return {s10, addr_e == 5'h00, ser_e & s10, s10 & cfg_e[5], s10 & !cfg_e[5],
         cfg_e[4] & !fdx, cfg_e[3], !cfg_e[3], cfg_e[2], cfg_e[0] & (fdx | lpbk),
         ind_mode ? conn_e : ind_norm};
   endfunction : exp_pins

   function automatic logic [15:0] exp_read(input logic [4:0] ra);
      logic [10:0] s;
      s = exp_pins();
      case (ra)
         PAT_REG_ADDR_SPEED: return {9'h000, s[10], conn_e, addr_e};
         PAT_REG_TEN_STATUS: return {6'h00, ser_e, 9'h000};
         PAT_REG_TEN_CONFIG: return cfg_e & 16'h003d;
         default: return 16'h0000;
      endcase
   endfunction : exp_read

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic test_done();
      if (err_total == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   // hang guard: whole run needs well under a thousand cycles
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         test_done();
      end
   end

   // read back every mapped register and the derived outputs
   task automatic check_all();
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? PAT_REG_ADDR_SPEED : (i == 1) ? PAT_REG_TEN_STATUS : PAT_REG_TEN_CONFIG;
         i_sme.access(a, 1'h0, 16'h0000, q);
         chk(q, exp_read(a));
      end
      chk({5'h00, pins}, exp_pins());
   endtask : check_all

   initial begin
      v = $urandom(32'he1b3);
      // straps of all zeros first, then a random address; straps stay steady
      for (int r = 0; r < 2; r++) begin
         v = $urandom;
         straps <= (r == 0) ? 5'h00 : (v[4:0] | 5'h01);
         ser_strap <= v[5];
         ind_mode <= v[6];
         ind_norm <= v[7];
         rst_b_in <= 1'h0;
         repeat (3) @(posedge mclk_in);
         rst_b_in <= 1'h1;
         repeat (8) @(posedge mclk_in);
         addr_e = straps;
         ser_e = ser_strap;
         cfg_e = 16'h0039;
         conn_e = 1'h0;
         check_all();
      end
      // connect status latches a loss and recovers on a read of the register
      for (int k = 0; k < 2; k++) begin
         i_sme.access(5'h05, 1'h0, 16'h0000, q);
         chk(q, 16'h0000);
         disc_ok <= 1'h0;
         repeat (6) @(posedge mclk_in);
         disc_ok <= 1'h1;
         repeat (6) @(posedge mclk_in);
         conn_e = 1'h0;
         i_sme.access(PAT_REG_ADDR_SPEED, 1'h0, 16'h0000, q);
         chk(q, exp_read(PAT_REG_ADDR_SPEED));
         conn_e = 1'h1;
         i_sme.access(PAT_REG_ADDR_SPEED, 1'h0, 16'h0000, q);
         chk(q, exp_read(PAT_REG_ADDR_SPEED));
      end
      // random writes, mode inputs and places, an unmapped one among them
      repeat (60) begin
         v = $urandom;
         cfg_100 <= v[0];
         an_en <= v[1];
         fdx <= v[2];
         lpbk <= v[3];
         ind_mode <= v[4];
         ind_norm <= v[5];
         case (v[7:6])
            2'h0: a = PAT_REG_ADDR_SPEED;
            2'h1: a = PAT_REG_TEN_STATUS;
            2'h2: a = PAT_REG_TEN_CONFIG;
            default: a = 5'h05;
         endcase
         i_sme.access(a, 1'h1, v[31:16], q);
         if (a == PAT_REG_ADDR_SPEED) begin
            addr_e = v[20:16];
         end else if (a == PAT_REG_TEN_STATUS) begin
            ser_e = v[25];
         end else if (a == PAT_REG_TEN_CONFIG) begin
            cfg_e = v[31:16] & 16'h003d;
         end
         i_sme.access(a, 1'h0, 16'h0000, q);
         chk(q, exp_read(a));
         chk({5'h00, pins}, exp_pins());
      end
      test_done();
   end
endmodule : phy_addr_and_tenbase_cfg_regs_tb_top
